/* File: logic/dnoc_top.v */
/*
  Register bank and control logic: overrange flags and pins, NCO preset
  storage and selection, channel binding, power-down, phase sync arming.
  Assumes AXI4-Lite from a single master, samples synchronous to aclk,
  preset pins and the SYSREF pin asynchronous.
*/
// Our own choice: register access over AXI4-Lite.
// Functional notes
// - Threshold high hit sets overrange bit one
// - Threshold low hit sets overrange bit zero
// - Pin enable low forces all pins low
// - Embedded status bits ignore the pin enable
// - Stretch pins to eight times two^exponent cycles
// - Exponent change may shift monitoring phase
// - Four presets per converter, frequency and phase
// - Source mode picks register or pin selection
// - Register selection uses low and high pairs
// - Binding bit one routes digital channel B
// - Binding bit zero routes digital channel A
// - Digital channel follows bound converter power-down
// - One sixteen-bit divisor serves all presets
// - Lane alignment edge initialises phase when set
// - Armed sync takes only next SYSREF edge
// - Frequency word signed or unsigned interpretation
// - Phase word placed at top of 32 bits
// - Read-only five-bit spin code, upper zero
`timescale 1ns/1ps
`default_nettype none
`include "dnoc_regs.vh"

module dnoc_top #(
  parameter SAMPLE_W = 8,
  parameter [4:0] SPIN_CODE = 5'h0A  // Arbitrary value
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Sample magnitudes, one per converter
  input wire [SAMPLE_W-1:0] level_conv_a,
  input wire [SAMPLE_W-1:0] level_conv_b,
  // Asynchronous pins
  input wire [1:0] preset_pins_a,
  input wire [1:0] preset_pins_b,
  input wire sysref_pin,
  // Lane alignment start, LMFC edge
  input wire ila_lmfc_edge,
  // Overrange pins
  output reg chan_a_range_flag_0,
  output reg chan_a_range_flag_1,
  output reg chan_b_range_flag_0,
  output reg chan_b_range_flag_1,
  // Embedded status for the data samples {conv b, conv a}, bit1:bit0
  output reg [3:0] sample_status_q,
  // Active NCO settings
  output reg [31:0] active_freq_a,
  output reg [31:0] active_freq_b,
  output reg [31:0] active_phase_a,
  output reg [31:0] active_phase_b,
  output reg [15:0] active_rdiv,
  output reg nco_phase_init,
  // Routing and power
  output reg route_select_a,
  output reg route_select_b,
  output reg digital_pd_a,
  output reg digital_pd_b,
  output reg link_enable_out
);

  //////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] thr_low_q;
  reg [7:0] thr_high_q;
  reg [3:0] overrange_config_q;
  reg [1:0] src_mode_q;
  reg [3:0] sel_q;
  reg [1:0] bind_q;
  reg [15:0] rdiv_q;
  reg [1:0] sync_q;
  reg [2:0] ctrl_q;
  reg [31:0] freq_q [0:7];
  reg [15:0] phase_q [0:7];
  reg armed_q;

  // Synchronisers
  reg [1:0] pins_a_s1_q, pins_a_s2_q;
  reg [1:0] pins_b_s1_q, pins_b_s2_q;
  reg sysref_s1_q, sysref_s2_q, sysref_prev_q;

  //////////////////////////////////////////////////////////////////////
  // AXI write channel: take address and data in either order
  reg aw_held_q, w_held_q;
  reg [11:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire wr_go;
  wire [9:0] wr_idx;
  wire wr_hit;
  integer i;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_idx = aw_addr_q[11:2];
  assign wr_hit = (wr_idx >= `DNOC_IDX_THR_LOW &&
                   wr_idx <= `DNOC_IDX_CTRL) ||
                  (wr_idx >= `DNOC_IDX_FREQ_BASE &&
                   wr_idx < `DNOC_IDX_PHASE_BASE + 10'h008);

  // Byte-lane merge for 32-bit fields
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge[k*8 +: 8] = strb[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DNOC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `DNOC_RESP_OKAY : `DNOC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register storage; reserved bits are not stored and read zero
  wire wb0 = wr_go && w_strb_q[0];
  wire [2:0] fslot = wr_idx[2:0];
  // 16-bit fields merge in a 32-bit word, upper half dropped on purpose
  wire [31:0] rdiv_m = merge({16'h0000, rdiv_q}, w_data_q, w_strb_q);
  wire [31:0] phase_m = merge({16'h0000, phase_q[fslot]}, w_data_q,
                              w_strb_q);

  always @(posedge aclk) begin
    if (!aresetn) begin
      thr_low_q <= `DNOC_RST_THR_LOW;
      thr_high_q <= `DNOC_RST_THR_HIGH;
      overrange_config_q <= `DNOC_RST_OVERRANGE_CONFIG;
      src_mode_q <= `DNOC_MODE_REG;
      sel_q <= 4'h0;
      bind_q <= `DNOC_RST_BIND;
      rdiv_q <= `DNOC_RST_RDIV;
      sync_q <= `DNOC_RST_SYNC;
      ctrl_q <= 3'h0;
      for (i = 0; i < 8; i = i + 1) begin
        freq_q[i] <= `DNOC_RST_FREQ;
        phase_q[i] <= `DNOC_RST_PHASE;
      end
    end else if (wr_go) begin
      case (wr_idx)
        `DNOC_IDX_THR_LOW: if (wb0) thr_low_q <= w_data_q[7:0];
        `DNOC_IDX_THR_HIGH: if (wb0) thr_high_q <= w_data_q[7:0];
        `DNOC_IDX_OVERRANGE_CONFIG: if (wb0) overrange_config_q <= w_data_q[3:0];
        `DNOC_IDX_SRC_MODE: if (wb0) src_mode_q <= w_data_q[1:0];
        `DNOC_IDX_SEL: if (wb0) sel_q <= w_data_q[3:0];
        // Binding is changed by software with link held off
        `DNOC_IDX_BIND: if (wb0) bind_q <= w_data_q[1:0];
        `DNOC_IDX_RDIV: rdiv_q <= rdiv_m[15:0];
        `DNOC_IDX_SYNC: if (wb0) sync_q <= w_data_q[1:0];
        `DNOC_IDX_CTRL: if (wb0) ctrl_q <= w_data_q[2:0];
        default: begin
          if (wr_idx >= `DNOC_IDX_FREQ_BASE &&
              wr_idx < `DNOC_IDX_PHASE_BASE) begin
            freq_q[fslot] <= merge(freq_q[fslot], w_data_q,
                                   w_strb_q);
          end else if (wr_idx >= `DNOC_IDX_PHASE_BASE &&
                       wr_idx < `DNOC_IDX_PHASE_BASE + 10'h008) begin
            phase_q[fslot] <= phase_m[15:0];
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // AXI read channel, one cycle after address
  reg [31:0] rd_word;
  wire [9:0] rd_idx = s_axi_araddr[11:2];
  reg rd_ok;

  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    case (rd_idx)
      `DNOC_IDX_THR_LOW: rd_word = {24'h000000, thr_low_q};
      `DNOC_IDX_THR_HIGH: rd_word = {24'h000000, thr_high_q};
      `DNOC_IDX_OVERRANGE_CONFIG: rd_word = {28'h0000000, overrange_config_q};
      `DNOC_IDX_SRC_MODE: rd_word = {30'h00000000, src_mode_q};
      `DNOC_IDX_SEL: rd_word = {28'h0000000, sel_q};
      `DNOC_IDX_BIND: rd_word = {30'h00000000, bind_q};
      `DNOC_IDX_RDIV: rd_word = {16'h0000, rdiv_q};
      `DNOC_IDX_SYNC: rd_word = {29'h00000000, armed_q, sync_q};
      `DNOC_IDX_CTRL: rd_word = {29'h00000000, ctrl_q};
      // Upper 27 bits read as zero
      `DNOC_IDX_SPIN: rd_word = {27'h0000000, SPIN_CODE};
      default: begin
        if (rd_idx >= `DNOC_IDX_FREQ_BASE &&
            rd_idx < `DNOC_IDX_PHASE_BASE) begin
          rd_word = freq_q[rd_idx[2:0]];
        end else if (rd_idx >= `DNOC_IDX_PHASE_BASE &&
                     rd_idx < `DNOC_IDX_PHASE_BASE + 10'h008) begin
          rd_word = {16'h0000, phase_q[rd_idx[2:0]]};
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `DNOC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? `DNOC_RESP_OKAY : `DNOC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Overrange detection, four stretchers share one exponent
  // Exponent changes take effect mid-window, so phase may shift
  wire [3:0] hit;
  wire [3:0] held;
  wire [SAMPLE_W-1:0] thr_lo_w = thr_low_q[7:0];
  wire [SAMPLE_W-1:0] thr_hi_w = thr_high_q[7:0];

  dnoc_stretch #(.SAMPLE_W(SAMPLE_W)) u_a0 (
    .aclk(aclk), .aresetn(aresetn), .level(level_conv_a),
    .threshold(thr_lo_w), .exponent(overrange_config_q[2:0]),
    .detect(hit[0]), .stretched_q(held[0]));
  dnoc_stretch #(.SAMPLE_W(SAMPLE_W)) u_a1 (
    .aclk(aclk), .aresetn(aresetn), .level(level_conv_a),
    .threshold(thr_hi_w), .exponent(overrange_config_q[2:0]),
    .detect(hit[1]), .stretched_q(held[1]));
  dnoc_stretch #(.SAMPLE_W(SAMPLE_W)) u_b0 (
    .aclk(aclk), .aresetn(aresetn), .level(level_conv_b),
    .threshold(thr_lo_w), .exponent(overrange_config_q[2:0]),
    .detect(hit[2]), .stretched_q(held[2]));
  dnoc_stretch #(.SAMPLE_W(SAMPLE_W)) u_b1 (
    .aclk(aclk), .aresetn(aresetn), .level(level_conv_b),
    .threshold(thr_hi_w), .exponent(overrange_config_q[2:0]),
    .detect(hit[3]), .stretched_q(held[3]));

  wire pin_en = overrange_config_q[`DNOC_OVERRANGE_PIN_ENABLE_BIT];

  always @(posedge aclk) begin
    if (!aresetn) begin
      sample_status_q <= 4'h0;
      chan_a_range_flag_0 <= 1'b0;
      chan_a_range_flag_1 <= 1'b0;
      chan_b_range_flag_0 <= 1'b0;
      chan_b_range_flag_1 <= 1'b0;
    end else begin
      sample_status_q <= hit;
      chan_a_range_flag_0 <= pin_en & held[0];
      chan_a_range_flag_1 <= pin_en & held[1];
      chan_b_range_flag_0 <= pin_en & held[2];
      chan_b_range_flag_1 <= pin_en & held[3];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Preset selection
  reg [1:0] idx_a, idx_b;

  always @* begin
    case (src_mode_q)
      `DNOC_MODE_PINS_AB: begin
        idx_a = pins_a_s2_q;
        idx_b = pins_b_s2_q;
      end
      `DNOC_MODE_PINS_A: begin
        idx_a = pins_a_s2_q;
        idx_b = pins_a_s2_q;
      end
      default: begin
        // Reserved mode falls back to register selection
        idx_a = sel_q[1:0];
        idx_b = sel_q[3:2];
      end
    endcase
  end

  // Frequency word passes unchanged; sign reading is downstream's choice
  always @(posedge aclk) begin
    if (!aresetn) begin
      active_freq_a <= `DNOC_RST_FREQ;
      active_freq_b <= `DNOC_RST_FREQ;
      active_phase_a <= 32'h00000000;
      active_phase_b <= 32'h00000000;
      active_rdiv <= `DNOC_RST_RDIV;
    end else begin
      active_freq_a <= freq_q[{1'b0, idx_a}];
      active_freq_b <= freq_q[{1'b1, idx_b}];
      active_phase_a <= {phase_q[{1'b0, idx_a}], 16'h0000};
      active_phase_b <= {phase_q[{1'b1, idx_b}], 16'h0000};
      active_rdiv <= rdiv_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Binding and power-down
  always @(posedge aclk) begin
    if (!aresetn) begin
      route_select_a <= 1'b0;
      route_select_b <= 1'b1;
      digital_pd_a <= 1'b0;
      digital_pd_b <= 1'b0;
      link_enable_out <= 1'b0;
    end else begin
      route_select_a <= bind_q[0];
      route_select_b <= bind_q[1];
      digital_pd_a <= bind_q[0] ? ctrl_q[`DNOC_CTRL_PDB_BIT]
                                : ctrl_q[`DNOC_CTRL_PDA_BIT];
      digital_pd_b <= bind_q[1] ? ctrl_q[`DNOC_CTRL_PDB_BIT]
                                : ctrl_q[`DNOC_CTRL_PDA_BIT];
      link_enable_out <= ctrl_q[`DNOC_CTRL_LINK_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Phase sync: arm on a written 0 then 1, fire once on SYSREF
  wire arm_wr = wr_go && wb0 && wr_idx == `DNOC_IDX_SYNC;
  wire arm_rise = arm_wr && w_data_q[`DNOC_SYNC_ARM_BIT] &&
                  !sync_q[`DNOC_SYNC_ARM_BIT];
  wire sysref_rise = sysref_s2_q && !sysref_prev_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      pins_a_s1_q <= 2'h0;
      pins_a_s2_q <= 2'h0;
      pins_b_s1_q <= 2'h0;
      pins_b_s2_q <= 2'h0;
      sysref_s1_q <= 1'b0;
      sysref_s2_q <= 1'b0;
      sysref_prev_q <= 1'b0;
      armed_q <= 1'b0;
      nco_phase_init <= 1'b0;
    end else begin
      pins_a_s1_q <= preset_pins_a;
      pins_a_s2_q <= pins_a_s1_q;
      pins_b_s1_q <= preset_pins_b;
      pins_b_s2_q <= pins_b_s1_q;
      sysref_s1_q <= sysref_pin;
      sysref_s2_q <= sysref_s1_q;
      sysref_prev_q <= sysref_s2_q;
      // Arming write wins over a coincident edge
      if (arm_rise) begin
        armed_q <= 1'b1;
      end else if (armed_q && sysref_rise) begin
        armed_q <= 1'b0;
      end
      nco_phase_init <= (armed_q && sysref_rise && !arm_rise) ||
                        (sync_q[`DNOC_SYNC_ILA_BIT] &&
                         ila_lmfc_edge);
    end
  end

endmodule
`default_nettype wire

/* File: logic/dnoc_regs.vh */
/*
  Register map, field positions and reset values for the overrange,
  preset-select, binding and oscillator control bank.
  Assumes a 32-bit AXI4-Lite slave with byte address = 4 * index.
*/
`ifndef DNOC_REGS_VH
`define DNOC_REGS_VH

// Printed register indices
`define DNOC_IDX_THR_LOW 10'h211
`define DNOC_IDX_THR_HIGH 10'h212
`define DNOC_IDX_OVERRANGE_CONFIG 10'h213
`define DNOC_IDX_SRC_MODE 10'h214
`define DNOC_IDX_SEL 10'h215
`define DNOC_IDX_BIND 10'h216
`define DNOC_IDX_RDIV 10'h217
`define DNOC_IDX_SYNC 10'h219
`define DNOC_IDX_SPIN 10'h297
// Chosen: preset words, index base, A presets then B presets
`define DNOC_IDX_FREQ_BASE 10'h220
`define DNOC_IDX_PHASE_BASE 10'h228
`define DNOC_IDX_CTRL 10'h21A

// Reset values
`define DNOC_RST_THR_LOW 8'hF2
`define DNOC_RST_THR_HIGH 8'hAB
`define DNOC_RST_OVERRANGE_CONFIG 4'h7
`define DNOC_RST_BIND 2'h2
`define DNOC_RST_RDIV 16'h0000
`define DNOC_RST_SYNC 2'h2
`define DNOC_RST_FREQ 32'hC0000000
`define DNOC_RST_PHASE 16'h0000

// Field positions
`define DNOC_OVERRANGE_PIN_ENABLE_BIT 3
`define DNOC_SYNC_ILA_BIT 1
`define DNOC_SYNC_ARM_BIT 0
`define DNOC_CTRL_LINK_BIT 0
`define DNOC_CTRL_PDA_BIT 1
`define DNOC_CTRL_PDB_BIT 2

// Preset source modes
`define DNOC_MODE_REG 2'h0
`define DNOC_MODE_PINS_AB 2'h1
`define DNOC_MODE_PINS_A 2'h2

// Stretch base count
`define DNOC_STRETCH_BASE 11'h008

// AXI responses
`define DNOC_RESP_OKAY 2'h0
`define DNOC_RESP_SLVERR 2'h2

`endif

/* File: logic/dnoc_stretch.v */
/*
  Overrange detector and pulse stretcher for one threshold.
  Assumes the sample magnitude is already on the device clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dnoc_regs.vh"

module dnoc_stretch #(
  parameter SAMPLE_W = 8
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Detection
  input wire [SAMPLE_W-1:0] level,
  input wire [SAMPLE_W-1:0] threshold,
  input wire [2:0] exponent,
  // Results
  output wire detect,
  output reg stretched_q
);

  reg [10:0] count_q;
  wire [10:0] span;

  assign detect = (level >= threshold);
  assign span = `DNOC_STRETCH_BASE << exponent;

  // Each new hit reloads the window so the output lasts at least span
  always @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 11'h000;
      stretched_q <= 1'b0;
    end else if (detect) begin
      count_q <= span - 11'h001;
      stretched_q <= 1'b1;
    end else if (count_q != 11'h000) begin
      count_q <= count_q - 11'h001;
    end else begin
      stretched_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: testbench/dnoc_checker.sv */
/*
  Port-level assertions for the control bank top.
  Assumes it is bound to dnoc_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module dnoc_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Overrange
  input wire logic [3:0] sample_status_q,
  input wire logic chan_a_range_flag_0,
  input wire logic chan_a_range_flag_1,
  input wire logic chan_b_range_flag_0,
  // Oscillator
  input wire logic [31:0] active_phase_a,
  input wire logic [31:0] active_phase_b,
  input wire logic nco_phase_init,
  input wire logic sysref_pin,
  input wire logic ila_lmfc_edge
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_held8;
    chan_a_range_flag_1 [*8];
  endsequence
  // A sync pulse must trace back to an LMFC edge or a SYSREF level
  sequence s_init_cause;
    $past(ila_lmfc_edge) || $past(ila_lmfc_edge, 2) || $past(sysref_pin, 3);
  endsequence
  ////////////////////////////////////////////////////////////////////
  AST_FLAG_A0_CAUSE: assert property (
    $rose(chan_a_range_flag_0) |-> $past(sample_status_q[0]))
    else $error("pin a0 rose without a low threshold hit");
  AST_FLAG_A1_CAUSE: assert property (
    $rose(chan_a_range_flag_1) |-> $past(sample_status_q[1]))
    else $error("pin a1 rose without a high threshold hit");
  AST_FLAG_B0_CAUSE: assert property (
    $rose(chan_b_range_flag_0) |-> $past(sample_status_q[2]))
    else $error("pin b0 rose without a low threshold hit");
  AST_STRETCH_MIN: assert property (
    $rose(chan_a_range_flag_1) |-> s_held8)
    else $error("overrange pulse shorter than eight cycles");
  AST_INIT_CAUSE: assert property (
    nco_phase_init |-> s_init_cause)
    else $error("phase init without a cause");
  AST_INIT_PULSE: assert property (
    nco_phase_init |=> !nco_phase_init)
    else $error("phase init longer than one cycle");
  AST_PHASE_JUST: assert property (
    active_phase_a[15:0] == 16'h0000 && active_phase_b[15:0] == 16'h0000)
    else $error("phase word not at top of field");
  AST_BVALID_ONE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_READ_REFUSE: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
endmodule
bind dnoc_top dnoc_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .sample_status_q(sample_status_q),
  .chan_a_range_flag_0(chan_a_range_flag_0),
  .chan_a_range_flag_1(chan_a_range_flag_1),
  .chan_b_range_flag_0(chan_b_range_flag_0),
  .active_phase_a(active_phase_a), .active_phase_b(active_phase_b),
  .nco_phase_init(nco_phase_init), .sysref_pin(sysref_pin),
  .ila_lmfc_edge(ila_lmfc_edge));
`default_nettype wire

/* File: testbench/dnoc_sysref_src.sv */
/*
  Behavioural SYSREF source driving the device pin.
  Assumes fire is a one-cycle request on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module dnoc_sysref_src (
  // Clock
  input wire logic aclk,
  // Request and pin
  input wire logic fire,
  output var logic sysref_pin
);
  logic [2:0] cnt_q = 3'h0;
  // Pin idles low between pulses so no stray edge fires an armed sync
  always @(posedge aclk) begin
    if (fire) cnt_q <= 3'h4;
    else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
    sysref_pin <= fire || (cnt_q > 3'h1);
  end
endmodule
`default_nettype wire

/* File: testbench/dnoc_top_tb_top.sv */
/*
  Register-level testbench for the control bank.
  Assumes a 4 ns clock and the chosen register indices.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dnoc_regs.vh"
module dnoc_top_tb_top;
  localparam logic [4:0] SPIN = 5'h0A; // Arbitrary value
  logic aclk, aresetn, awvalid, wvalid, arvalid, fire, ila;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r, pa, pb;
  logic [7:0] la, lb;
  logic awready, wready, bvalid, arready, rvalid, sref, f0, f1, f2, f3;
  logic [3:0] st;
  logic [31:0] fa, fb, pha, phb, c;
  logic [15:0] rdv;
  logic ini, rsa, rsb, pda, pdb, le;
  logic [2:0] k, m;
  int err_count, num_checks;
  dnoc_top #(.SPIN_CODE(SPIN)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .level_conv_a(la),
    .level_conv_b(lb), .preset_pins_a(pa), .preset_pins_b(pb),
    .sysref_pin(sref), .ila_lmfc_edge(ila), .chan_a_range_flag_0(f0),
    .chan_a_range_flag_1(f1), .chan_b_range_flag_0(f2),
    .chan_b_range_flag_1(f3), .sample_status_q(st), .active_freq_a(fa),
    .active_freq_b(fb), .active_phase_a(pha), .active_phase_b(phb),
    .active_rdiv(rdv), .nco_phase_init(ini), .route_select_a(rsa),
    .route_select_b(rsb), .digital_pd_a(pda), .digital_pd_b(pdb),
    .link_enable_out(le));
  dnoc_sysref_src u_src (.aclk(aclk), .fire(fire), .sysref_pin(sref));
  always #2 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [9:0] idx, input logic [31:0] v);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= {idx, 2'h0};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk("bresp", bresp, `DNOC_RESP_OKAY);
  endtask
  task automatic rd(input logic [9:0] idx);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask
  task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
    rd(idx);
    chk("rdata", d, exp);
    chk("rresp", r, `DNOC_RESP_OKAY);
  endtask
  task automatic ovr(input logic en, input logic [2:0] n);
    logic [31:0] ca0, ca1, cb0, cb1, cs, lo;
    ca0 = 0; ca1 = 0; cb0 = 0; cb1 = 0; cs = 0; lo = 32'h8 << n;
    wr(`DNOC_IDX_OVERRANGE_CONFIG, {28'h0, en, n});
    la <= 8'hB0;
    lb <= 8'hF8;
    @(posedge aclk);
    la <= 8'h00;
    lb <= 8'h00;
    repeat (lo + 20) begin
      @(posedge aclk);
      ca0 += f0; ca1 += f1; cb0 += f2; cb1 += f3; cs += (st === 4'hE);
    end
    chk("status", cs, 1);
    chk("pin a0", ca0, 0);
    chk("pin a1", en ? (ca1 >= lo && ca1 < 2 * lo) : ca1, en);
    chk("pin b0", en ? (cb0 >= lo && cb0 < 2 * lo) : cb0, en);
    chk("pin b1", en ? (cb1 >= lo && cb1 < 2 * lo) : cb1, en);
  endtask
  task automatic chkp(input logic [1:0] ka, kb);
    repeat (6) @(posedge aclk);
    chk("freq a", fa, {30'h28000000, ka});
    chk("freq b", fb, {30'h2C000000, kb});
    chk("phase a", pha, {14'h2800, ka, 16'h0});
    chk("phase b", phb, {14'h2C00, kb, 16'h0});
  endtask
  task automatic ev(input logic s, i, input logic [31:0] exp);
    fire <= s;
    ila <= i;
    @(posedge aclk);
    fire <= 1'b0;
    ila <= 1'b0;
    c = 0;
    repeat (20) begin
      @(posedge aclk);
      c += ini;
    end
    chk("init pulses", c, exp);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge aclk);
    err_count++;
    wrap_up();
  end
  initial begin
    aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; arvalid = 0;
    fire = 0; ila = 0; awaddr = 0; araddr = 0; wdata = 0;
    la = 0; lb = 0; pa = 0; pb = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(`DNOC_IDX_THR_LOW, 32'hF2);
    rchk(`DNOC_IDX_THR_HIGH, 32'hAB);
    rchk(`DNOC_IDX_OVERRANGE_CONFIG, 32'h07);
    rchk(`DNOC_IDX_BIND, 32'h02);
    rchk(`DNOC_IDX_SYNC, 32'h02);
    rchk(`DNOC_IDX_FREQ_BASE, 32'hC0000000);
    rchk(`DNOC_IDX_SPIN, {27'h0, SPIN});
    rd(10'h300);
    chk("unmapped resp", r, `DNOC_RESP_SLVERR);
    chk("unmapped data", d, 0);
    ovr(1'b1, 3'h0);
    ovr(1'b1, 3'h3);
    ovr(1'b1, 3'h7);
    ovr(1'b0, 3'h2);
    wr(`DNOC_IDX_THR_HIGH, 32'h55);
    rchk(`DNOC_IDX_THR_HIGH, 32'h55);
    wr(`DNOC_IDX_RDIV, 32'hBEEF);
    rchk(`DNOC_IDX_RDIV, 32'hBEEF);
    chk("rdiv", rdv, 16'hBEEF);
    for (k = 0; k < 4; k++) begin
      wr(`DNOC_IDX_FREQ_BASE + {7'h0, k}, {30'h28000000, k[1:0]});
      wr(`DNOC_IDX_FREQ_BASE + {7'h0, k} + 10'h4, {30'h2C000000, k[1:0]});
      wr(`DNOC_IDX_PHASE_BASE + {7'h0, k}, {16'h0, 14'h2800, k[1:0]});
      wr(`DNOC_IDX_PHASE_BASE + {7'h0, k} + 10'h4, {16'h0, 14'h2C00, k[1:0]});
    end
    for (m = 0; m < 4; m++) begin
      wr(`DNOC_IDX_SRC_MODE, {29'h0, m});
      for (k = 0; k < 4; k++) begin
        wr(`DNOC_IDX_SEL, {28'h0, k[1:0], ~k[1:0]});
        pa <= k[1:0];
        pb <= ~k[1:0];
        // Reserved mode 3 behaves as register selection
        chkp(m[0] == m[1] ? ~k[1:0] : k[1:0], m == 1 ? ~k[1:0] : k[1:0]);
      end
    end
    // Link stays off while binding changes
    wr(`DNOC_IDX_CTRL, 32'h2);
    wr(`DNOC_IDX_BIND, 32'h1);
    repeat (3) @(posedge aclk);
    chk("route a", rsa, 1);
    chk("route b", rsb, 0);
    chk("pd a", pda, 0);
    chk("pd b", pdb, 1);
    chk("link", le, 0);
    wr(`DNOC_IDX_BIND, 32'h2);
    repeat (3) @(posedge aclk);
    chk("pd a", pda, 1);
    chk("pd b", pdb, 0);
    wr(`DNOC_IDX_CTRL, 32'h1);
    repeat (3) @(posedge aclk);
    chk("link", le, 1);
    wr(`DNOC_IDX_SYNC, 32'h0);
    wr(`DNOC_IDX_SYNC, 32'h1);
    ev(1'b1, 1'b0, 1);
    ev(1'b1, 1'b0, 0);
    ev(1'b0, 1'b1, 0);
    wr(`DNOC_IDX_SYNC, 32'h2);
    ev(1'b0, 1'b1, 1);
    wrap_up();
  end
endmodule
`default_nettype wire
